// ==== pkg/analog_test_regs.svh ====
/*
  Register offsets, field positions and reset values of the analog bench
  test control block. Assumes inclusion by bare name from the package and RTL.
*/
`ifndef ANALOG_TEST_REGS_SVH
`define ANALOG_TEST_REGS_SVH

`define ATC_OFFSET_CONTROL     32'h0000_0000
`define ATC_OFFSET_SELECT      32'h0000_0004
`define ATC_OFFSET_STATUS      32'h0000_0008

`define ATC_BIT_MASTER_DISABLE 0
`define ATC_BIT_BENCH_ENABLE   1
`define ATC_BIT_LOW_DISABLE    2
`define ATC_BIT_HIGH_DISABLE   3
`define ATC_BIT_RESERVED_LOW   4
`define ATC_BIT_RESERVED_HIGH  7

`define ATC_CONTROL_RESET      8'h81
`define ATC_CONTROL_WMASK      8'h0f
`define ATC_SELECT_RESET       5'h00

`define AXI_RESP_OKAY          2'h0
`define AXI_RESP_SLVERR        2'h2

`endif

// ==== pkg/analog_test_pkg.sv ====
/*
  Types shared by the analog bench test control block.
  Assumes the register header sits on the include path.
*/
`include "analog_test_regs.svh"

package analog_test_pkg;

  typedef struct packed {
    logic high_side_gate;
    logic low_side_gate;
    logic switch_node_drive_en;
  } gate_drive_t;

  typedef struct packed {
    logic       bench_route;
    logic [4:0] analog_signal_select;
  } bench_out_t;

  typedef struct packed {
    logic [31:0] addr;
    logic        valid;
  } axi_addr_t;

  typedef struct packed {
    logic [31:0] data;
    logic [3:0]  strb;
    logic        valid;
  } axi_wdata_t;

  typedef struct packed {
    logic [31:0] data;
    logic [1:0]  resp;
    logic        valid;
  } axi_rdata_t;

endpackage

// ==== rtl/gate_drive_gate.sv ====
/*
  One gate driver output stage gate: passes the request only when enabled.
  Assumes synchronous inputs on clk_sys.
*/
`timescale 1ns/1ns

module gate_drive_gate (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic master_disable,
  input  wire logic side_disable,
  input  wire logic pwm_request,
  output logic      gate_out
);

  wire allow = ~master_disable & ~side_disable;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      gate_out <= 1'b0;
    end else begin
      gate_out <= allow & pwm_request; // see RL3 RL4
    end
  end

endmodule // gate_drive_gate

// ==== rtl/analog_test_control.sv ====
/*
  Analog bench test control register bank behind an AXI4-Lite slave.
  Holds driver disables and the bench test routing of the first port pin.
  Assumes one clock, synchronous active-low reset, PWM requests on clk_sys.
*/
// The implementer's own choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`include "analog_test_regs.svh"

// What this block does
// RL1 - Master driver disable bit resets to one, drivers start inactive.
// RL2 - Firmware clears the master disable before drivers switch normally.
// RL3 - Master disable set holds both gates low, switch node undriven.
// RL4 - Master disable clear lets drivers run, subject to side disables.
// RL5 - Bit 3 disables the high-side driver when one; resets zero.
// RL6 - Bit 2 disables the low-side driver when one; resets zero.
// RL7 - Bench bit one routes buffer output onto the first port pin.
// RL8 - Bench bit zero, its reset value, keeps normal pin function.
// RL9 - A 5-bit selector picks the analog signal shown in bench mode.
// RL10 - Bits 6,5 read zero; reserved bits 7,4 keep reset values.
module analog_test_control
  import analog_test_pkg::*;
(
  input  wire logic                  clk_sys,
  input  wire logic                  rst_n,
  input  wire logic [31:0]           s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [31:0]           s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire logic                  pwm_high_request,
  input  wire logic                  pwm_low_request,
  output analog_test_pkg::gate_drive_t gate_drive,
  output analog_test_pkg::bench_out_t  bench_out
);

  logic [7:0]  analog_test_control_q;
  logic [4:0]  analog_signal_select;
  logic        aw_held;
  logic        w_held;
  logic [31:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        high_gate;
  logic        low_gate;

  wire driver_master_disable = analog_test_control_q[`ATC_BIT_MASTER_DISABLE];
  wire bench_test_enable     = analog_test_control_q[`ATC_BIT_BENCH_ENABLE];
  wire low_side_disable      = analog_test_control_q[`ATC_BIT_LOW_DISABLE];
  wire high_side_disable     = analog_test_control_q[`ATC_BIT_HIGH_DISABLE];

  // Write channel: address and data captured independently, in any order
  wire aw_take   = s_axi_awvalid & s_axi_awready;
  wire w_take    = s_axi_wvalid & s_axi_wready;
  wire wr_fire   = aw_held & w_held & ~s_axi_bvalid;
  wire wr_ctrl   = aw_addr == `ATC_OFFSET_CONTROL;
  wire wr_sel    = aw_addr == `ATC_OFFSET_SELECT;
  wire wr_stat   = aw_addr == `ATC_OFFSET_STATUS;
  wire wr_mapped = wr_ctrl | wr_sel | wr_stat;

  // Only the four low control bits take writes; reserved and unused stay put
  wire [7:0] next_control = (analog_test_control_q & ~8'(`ATC_CONTROL_WMASK))
                          | (w_data[7:0] & 8'(`ATC_CONTROL_WMASK)); // see RL10

  wire rd_take   = s_axi_arvalid & s_axi_arready;
  wire rd_ctrl   = s_axi_araddr == `ATC_OFFSET_CONTROL;
  wire rd_sel    = s_axi_araddr == `ATC_OFFSET_SELECT;
  wire rd_stat   = s_axi_araddr == `ATC_OFFSET_STATUS;
  wire rd_mapped = rd_ctrl | rd_sel | rd_stat;

  // Bits 6 and 5 are masked off the read view; they always read zero
  wire [7:0]  control_view = analog_test_control_q & 8'h9f; // see RL10
  wire [31:0] status_view  = {29'h0, high_gate, low_gate, ~driver_master_disable};
  wire [31:0] next_rdata   = rd_ctrl ? {24'h0, control_view} :
                             rd_sel  ? {27'h0, analog_signal_select} :
                             rd_stat ? status_view : 32'h0000_0000;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= 32'h0000_0000;
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
    end else begin
      if (aw_take) begin
        aw_held       <= 1'b1;
        aw_addr       <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (w_take) begin
        w_held       <= 1'b1;
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (s_axi_bvalid & s_axi_bready) begin
        aw_held       <= 1'b0;
        w_held        <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `AXI_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_mapped ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Register bank; byte lane 0 carries every implemented bit
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      analog_test_control_q <= `ATC_CONTROL_RESET; // see RL1 RL5 RL6 RL8 RL10
      analog_signal_select  <= `ATC_SELECT_RESET;
    end else if (wr_fire & w_strb[0]) begin
      if (wr_ctrl) begin
        analog_test_control_q <= next_control; // see RL2
      end
      if (wr_sel) begin
        analog_signal_select <= w_data[4:0]; // see RL9
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `AXI_RESP_OKAY;
    end else if (rd_take) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= next_rdata;
      s_axi_rresp   <= rd_mapped ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
    end else if (s_axi_rvalid & s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  gate_drive_gate high_stage (
    .clk_sys        (clk_sys),
    .rst_n          (rst_n),
    .master_disable (driver_master_disable),
    .side_disable   (high_side_disable),
    .pwm_request    (pwm_high_request),
    .gate_out       (high_gate)
  ); // see RL5

  gate_drive_gate low_stage (
    .clk_sys        (clk_sys),
    .rst_n          (rst_n),
    .master_disable (driver_master_disable),
    .side_disable   (low_side_disable),
    .pwm_request    (pwm_low_request),
    .gate_out       (low_gate)
  ); // see RL6

  // Outputs registered; switch node enable and bench outputs run one cycle ahead of the gates
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      gate_drive <= '0;
      bench_out  <= '0;
    end else begin
      gate_drive.high_side_gate       <= high_gate;
      gate_drive.low_side_gate        <= low_gate;
      gate_drive.switch_node_drive_en <= ~driver_master_disable; // see RL3 RL4
      bench_out.bench_route           <= bench_test_enable; // see RL7 RL8
      bench_out.analog_signal_select  <= analog_signal_select; // see RL9
    end
  end

endmodule // analog_test_control

// ==== bench/analog_test_checker.sv ====
/* Port assertions for analog_test_control.
   Assumes one clock and a synchronous active-low reset. */
`timescale 1ns/1ns
module analog_test_checker
  import analog_test_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        pwm_high_request,
  input wire logic        pwm_low_request,
  input wire analog_test_pkg::gate_drive_t gate_drive
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_gates_off;
    !gate_drive.high_side_gate && !gate_drive.low_side_gate;
  endsequence
  property p_rst_gate; $rose(rst_n) |-> gate_drive == 3'h0; endproperty
  a_rst_gate: assert property (p_rst_gate) else $error("gates live at reset");
  // Node float leads the gates by one cycle
  property p_off; !gate_drive.switch_node_drive_en |=> s_gates_off; endproperty
  a_off: assert property (p_off) else $error("gate on while disabled");
  property p_hi;
    gate_drive.high_side_gate |->
      $past(pwm_high_request, 2) && $past(gate_drive.switch_node_drive_en);
  endproperty
  a_hi: assert property (p_hi) else $error("high gate without cause");
  property p_lo;
    gate_drive.low_side_gate |->
      $past(pwm_low_request, 2) && $past(gate_drive.switch_node_drive_en);
  endproperty
  a_lo: assert property (p_lo) else $error("low gate without cause");
  property p_wr; s_wr_taken |-> ##[1:2] s_axi_bvalid; endproperty
  a_wr: assert property (p_wr) else $error("write answer late");
  property p_busy; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  a_busy: assert property (p_busy) else $error("write taken while busy");
  property p_rd; s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid; endproperty
  a_rd: assert property (p_rd) else $error("read answer late");
  property p_rdhi; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0; endproperty
  a_rdhi: assert property (p_rdhi) else $error("upper read bits set");
endmodule // analog_test_checker

bind analog_test_control analog_test_checker i_chk (.clk_sys, .rst_n, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .pwm_high_request, .pwm_low_request,
  .gate_drive);

// ==== bench/analog_test_control_tb.sv ====
/* Self-checking bench for analog_test_control.
   Assumes the checker is bound in; bready and rready stay high. */
`timescale 1ns/1ns
module analog_test_control_tb;
  import analog_test_pkg::*;
  logic        clk_sys, rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready, pwm_high_request, pwm_low_request;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  gate_drive_t gate_drive;
  bench_out_t  bench_out;
  int          failures, samples_checked, i;
  analog_test_control i_dut (.clk_sys, .rst_n, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .pwm_high_request, .pwm_low_request, .gate_drive, .bench_out);
  always #5 clk_sys = ~clk_sys;
  task check(input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task final_report;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task tmo(input int n);
    if (n == 20) begin
      failures++;
      final_report;
    end
  endtask
  task wr(input logic [31:0] a, d, input logic [1:0] r);
    int n;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    tmo(n);
    check(s_axi_bresp, r);
  endtask
  task rd(input logic [31:0] a, d, input logic [1:0] r);
    int n;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    tmo(n);
    check(s_axi_rdata, d);
    check(s_axi_rresp, r);
  endtask
  // Gate path is two registers deep; three edges cover it
  task gates(input logic [2:0] g);
    repeat (3) @(posedge clk_sys);
    check(gate_drive, g);
  endtask
  task t_reset;
    rd(32'h0, 32'h81, 2'h0);
    gates(3'h0);
    check(bench_out, 6'h0);
    rd(32'h8, 32'h0, 2'h0);
  endtask
  task t_sides;
    for (i = 0; i < 4; i++) begin
      wr(32'h0, 32'(i << 2), 2'h0);
      gates({i[1] == 1'b0, i[0] == 1'b0, 1'b1});
      rd(32'h8, {29'h0, i[1] == 1'b0, i[0] == 1'b0, 1'b1}, 2'h0);
    end
    // Loop leaves both side disables set; clear them so the low gate can run
    wr(32'h0, 32'h0, 2'h0);
    pwm_high_request <= 1'b0;
    gates(3'h3);
    pwm_high_request <= 1'b1;
    wr(32'h0, 32'h1, 2'h0);
    gates(3'h0);
  endtask
  task t_bench;
    wr(32'h4, 32'hff, 2'h0);
    rd(32'h4, 32'h1f, 2'h0);
    wr(32'h4, 32'h1d, 2'h0);
    wr(32'h0, 32'h3, 2'h0);
    gates(3'h0);
    check(bench_out, {1'b1, 5'h1d});
    wr(32'h0, 32'h1, 2'h0);
    gates(3'h0);
    check(bench_out.bench_route, 1'b0);
  endtask
  task t_mask;
    wr(32'h0, 32'hf0, 2'h0);
    rd(32'h0, 32'h80, 2'h0);
    wr(32'h0, 32'hff, 2'h0);
    rd(32'h0, 32'h8f, 2'h0);
    wr(32'h10, 32'h0, 2'h2);
    rd(32'h10, 32'h0, 2'h2);
    // Lane 0 strobe low must leave the control word alone
    s_axi_wstrb <= 4'h0;
    wr(32'h0, 32'h80, 2'h0);
    s_axi_wstrb <= 4'hf;
    wr(32'h8, 32'h7, 2'h0);
    rd(32'h0, 32'h8f, 2'h0);
    rd(32'h8, 32'h0, 2'h0);
  endtask
  // Second reset from a dirty state: bench routed, select nonzero
  task t_rerst;
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(32'h0, 32'h81, 2'h0);
    rd(32'h4, 32'h0, 2'h0);
    check(bench_out, 6'h0);
  endtask
  initial begin
    {clk_sys, rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 5'h0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
    {s_axi_bready, s_axi_rready, pwm_high_request, pwm_low_request} = 4'hf;
    s_axi_wstrb = 4'hf;
    failures = 0;
    samples_checked = 0;
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_reset;
    t_sides;
    t_bench;
    t_mask;
    t_rerst;
    final_report;
  end
endmodule // analog_test_control_tb
